/* hw/prps_pkg.sv */
// Package for the peripheral pin route selector: register indices,
// field positions, reset values, route codes and signal numbering.
// Assumes ports A to F of eight pins each, pin index = port * 8 + pin.
package prps_pkg;

  localparam int NUM_PORTS = 6;
  localparam int PINS_PER_PORT = 8;
  localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;
  localparam int NUM_SIGS = 45;
  localparam int NUM_ROUTE_REGS = 8;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_SERIAL_ROUTE_B = 4'h3;
  localparam logic [3:0] IDX_SYNC_SERIAL_ROUTE = 4'h4;
  localparam logic [3:0] IDX_TWO_WIRE_ROUTE = 4'h5;
  localparam logic [3:0] IDX_TIMER_A_ROUTE = 4'h6;
  localparam logic [3:0] IDX_TIMER_B_ROUTE = 4'h7;
  localparam logic [3:0] IDX_TIMER_D_ROUTE = 4'h8;
  localparam logic [3:0] IDX_COMPARATOR_ROUTE = 4'h9;
  localparam logic [3:0] IDX_ZERO_CROSS_ROUTE = 4'hA;
  localparam logic [3:0] IDX_ROUTE_STATUS = 4'hB;

  localparam logic [7:0] ROUTE_RESET = 8'h00;

  // Implemented bits of each route register
  localparam logic [7:0] MASK_SERIAL_ROUTE_B = 8'h03;
  localparam logic [7:0] MASK_SYNC_SERIAL_ROUTE = 8'h0F;
  localparam logic [7:0] MASK_TWO_WIRE_ROUTE = 8'h0F;
  localparam logic [7:0] MASK_TIMER_A_ROUTE = 8'h3F;
  localparam logic [7:0] MASK_TIMER_B_ROUTE = 8'h0F;
  localparam logic [7:0] MASK_TIMER_D_ROUTE = 8'h07;
  localparam logic [7:0] MASK_COMPARATOR_ROUTE = 8'h07;
  localparam logic [7:0] MASK_ZERO_CROSS_ROUTE = 8'h03;

  // Field positions (least significant bit)
  localparam int LSB_SERIAL_FOUR = 0;
  localparam int LSB_SYNC_ONE = 2;
  localparam int LSB_SYNC_ZERO = 0;
  localparam int LSB_TWO_WIRE_ONE = 2;
  localparam int LSB_TWO_WIRE_ZERO = 0;
  localparam int LSB_TIMER_A_ONE = 3;
  localparam int LSB_TIMER_A_ZERO = 0;
  localparam int LSB_TIMER_D_ZERO = 0;

  // Two-bit route codes, and the highest three-bit timer A zero code
  localparam logic [1:0] CODE_DEFAULT = 2'h0;
  localparam logic [1:0] CODE_ALT_ONE = 2'h1;
  localparam logic [1:0] CODE_ALT_TWO = 2'h2;
  localparam logic [1:0] CODE_NONE = 2'h3;
  localparam logic [2:0] CODE_TIMER_A_ZERO_MAX = 3'h5;

  // Port numbers
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_F = 3'h5;

  // Peripheral signal numbering (base of each group)
  localparam int SIG_SERIAL_FOUR = 0;   // tx, rx, ext clock, direction
  localparam int SIG_SYNC_ONE = 4;      // mosi, miso, sck, ss
  localparam int SIG_SYNC_ZERO = 8;
  localparam int SIG_TWO_WIRE_ONE = 12; // sda, scl, dual sda, dual scl
  localparam int SIG_TWO_WIRE_ZERO = 16;
  localparam int SIG_TIMER_A_ONE = 20;  // waveform 0..5
  localparam int SIG_TIMER_A_ZERO = 26;
  localparam int SIG_TIMER_B = 32;      // timer 0..3
  localparam int SIG_TIMER_D = 36;      // waveform a..d
  localparam int SIG_COMPARATOR = 40;   // comparator 0..2
  localparam int SIG_ZERO_CROSS = 43;   // detector 0..1

  // Level a peripheral input sees while disconnected
  localparam logic [NUM_SIGS-1:0] SIG_IDLE = 45'h000_000_0FF_B2;

  typedef struct packed {
    logic [1:0] serial_port_four_sel;
    logic [1:0] sync_port_one_sel;
    logic [1:0] sync_port_zero_sel;
    logic [1:0] two_wire_one_sel;
    logic [1:0] two_wire_zero_sel;
    logic [2:0] timer_a_one_sel;
    logic [2:0] timer_a_zero_sel;
    logic [3:0] timer_b_sel;      // bit n routes type-B timer n
    logic [2:0] timer_d_zero_sel;
    logic [2:0] comparator_sel;   // bit n routes comparator n
    logic [1:0] zero_cross_sel;   // bit n routes detector n
  } prps_route_t;

  typedef struct packed {
    logic vld;
    logic [5:0] pin;
  } prps_place_t;

endpackage : prps_pkg

/* hw/prps_regs.sv */
// Avalon-MM register slave holding the eight route registers and the
// reserved-code status register. One wait state on every access.
// Assumes a master that holds its request until waitrequest is low.
`timescale 1ns/1ps
module prps_regs (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] route_status,
  output prps_pkg::prps_route_t route
);
  import prps_pkg::*;

  logic [7:0] reg_ff [NUM_ROUTE_REGS];
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [3:0] idx;
  logic req;
  logic aligned;

  function automatic logic [7:0] mask_of(input logic [3:0] i);
    case (i)
      IDX_SERIAL_ROUTE_B: mask_of = MASK_SERIAL_ROUTE_B;
      IDX_SYNC_SERIAL_ROUTE: mask_of = MASK_SYNC_SERIAL_ROUTE;
      IDX_TWO_WIRE_ROUTE: mask_of = MASK_TWO_WIRE_ROUTE;
      IDX_TIMER_A_ROUTE: mask_of = MASK_TIMER_A_ROUTE;
      IDX_TIMER_B_ROUTE: mask_of = MASK_TIMER_B_ROUTE;
      IDX_TIMER_D_ROUTE: mask_of = MASK_TIMER_D_ROUTE;
      IDX_COMPARATOR_ROUTE: mask_of = MASK_COMPARATOR_ROUTE;
      IDX_ZERO_CROSS_ROUTE: mask_of = MASK_ZERO_CROSS_ROUTE;
      default: mask_of = 8'h00;
    endcase
  endfunction : mask_of

  assign idx = avs_address[5:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  // Single wait state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Read data ready for the cycle waitrequest drops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= 32'h0000_0000;
      if (aligned && idx == IDX_ROUTE_STATUS) begin
        rdata_ff[7:0] <= route_status;
      end else if (aligned && mask_of(idx) != 8'h00) begin
        rdata_ff[7:0] <= reg_ff[3'(idx - IDX_SERIAL_ROUTE_B)];
      end
    end
  end

  // Write lands on the edge where waitrequest is low
  for (genvar r = 0; r < NUM_ROUTE_REGS; r++) begin : g_reg
    localparam logic [3:0] RIDX = IDX_SERIAL_ROUTE_B + 4'(r);
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        reg_ff[r] <= ROUTE_RESET;
      end else if (avs_write && ack_ff && aligned && avs_byteenable[0] &&
                   idx == RIDX) begin
        reg_ff[r] <= avs_writedata[7:0] & mask_of(RIDX);
      end
    end
  end

  always_comb begin
    route.serial_port_four_sel = reg_ff[0][LSB_SERIAL_FOUR +: 2];
    route.sync_port_one_sel = reg_ff[1][LSB_SYNC_ONE +: 2];
    route.sync_port_zero_sel = reg_ff[1][LSB_SYNC_ZERO +: 2];
    route.two_wire_one_sel = reg_ff[2][LSB_TWO_WIRE_ONE +: 2];
    route.two_wire_zero_sel = reg_ff[2][LSB_TWO_WIRE_ZERO +: 2];
    route.timer_a_one_sel = reg_ff[3][LSB_TIMER_A_ONE +: 3];
    route.timer_a_zero_sel = reg_ff[3][LSB_TIMER_A_ZERO +: 3];
    route.timer_b_sel = reg_ff[4][3:0];
    route.timer_d_zero_sel = reg_ff[5][LSB_TIMER_D_ZERO +: 3];
    route.comparator_sel = reg_ff[6][2:0];
    route.zero_cross_sel = reg_ff[7][1:0];
  end

endmodule : prps_regs

/* hw/prps_route_top.sv */
// Peripheral pin route selector: maps peripheral signals onto port pins
// as the route registers say, and feeds pin levels back to peripherals.
// Assumes pins and peripheral signals are synchronous to clk_sys.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps

// Functional notes
// - Serial port four: PE0-3, PE4-7, or none
// - Sync port one: PC0-3, PC4-7, PB4-7, none
// - Sync port zero: PA4-7, PE0-3, none
// - Two-wire one: PF2/3 or PB2/3 host, dual PB2/3 or PB6/7
// - Two-wire zero: PA2/3 or PC2/3 host, dual PC2/3 or PC6/7
// - Timer A one: PB0-5, PC4-6, PE4-6
// - Timer A zero: pins 0-5 of ports A-F
// - Timer B three: PB5 or PC1
// - Timer B two: PC0 or PB4
// - Timer B one: PA3 or PF5
// - Timer B zero: PA2 or PF4
// - Timer D: PA4-7, PB4-7, PF0-3
// - Comparators: PA7 or PC6 each
// - Zero-cross one: PA7 or PC7
// - Zero-cross register clears to zero
// - Zero-cross zero: PA7 or PC7
module prps_route_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [prps_pkg::NUM_SIGS-1:0] sig_out,
  input wire logic [prps_pkg::NUM_SIGS-1:0] sig_oe,
  output logic [prps_pkg::NUM_SIGS-1:0] sig_in,
  input wire logic [prps_pkg::NUM_PINS-1:0] pin_in,
  output logic [prps_pkg::NUM_PINS-1:0] pin_out,
  output logic [prps_pkg::NUM_PINS-1:0] pin_oe
);
  import prps_pkg::*;

  localparam prps_place_t NOWHERE = '0;

  prps_route_t route;
  prps_place_t place [NUM_SIGS];
  logic [7:0] route_status;
  logic [NUM_PINS-1:0] pin_out_ff;
  logic [NUM_PINS-1:0] pin_oe_ff;
  logic [NUM_SIGS-1:0] sig_in_ff;
  logic [NUM_PINS-1:0] nxt_pin_out;
  logic [NUM_PINS-1:0] nxt_pin_oe;
  logic [NUM_SIGS-1:0] nxt_sig_in;

  function automatic prps_place_t at(input logic [2:0] port,
                                     input logic [2:0] pin);
    prps_place_t p;
    p.vld = 1'b1;
    p.pin = {port, pin};
    return p;
  endfunction : at

  prps_regs u_regs (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .route_status(route_status),
    .route(route)
  );

  // Flags a reserved code held by each register
  always_comb begin
    route_status = 8'h00;
    route_status[0] = (route.serial_port_four_sel == CODE_ALT_TWO);
    route_status[1] = (route.sync_port_zero_sel == CODE_ALT_TWO);
    route_status[2] = (route.two_wire_one_sel == CODE_NONE) ||
                      (route.two_wire_zero_sel == CODE_NONE);
    route_status[3] = (route.timer_a_one_sel > 3'(CODE_ALT_TWO)) ||
                      (route.timer_a_zero_sel > CODE_TIMER_A_ZERO_MAX);
    route_status[5] = (route.timer_d_zero_sel > 3'(CODE_ALT_TWO));
  end

  // Placement of every peripheral signal
  always_comb begin
    for (int s = 0; s < NUM_SIGS; s++) begin
      place[s] = NOWHERE;
    end
    case (route.serial_port_four_sel)
      CODE_DEFAULT: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_SERIAL_FOUR + k] = at(PORT_E, 3'(k));
        end
      end
      CODE_ALT_ONE: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_SERIAL_FOUR + k] = at(PORT_E, 3'(4 + k));
        end
      end
      default: ;
    endcase
    case (route.sync_port_one_sel)
      CODE_DEFAULT: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_SYNC_ONE + k] = at(PORT_C, 3'(k));
        end
      end
      CODE_ALT_ONE: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_SYNC_ONE + k] = at(PORT_C, 3'(4 + k));
        end
      end
      CODE_ALT_TWO: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_SYNC_ONE + k] = at(PORT_B, 3'(4 + k));
        end
      end
      default: ;
    endcase
    case (route.sync_port_zero_sel)
      CODE_DEFAULT: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_SYNC_ZERO + k] = at(PORT_A, 3'(4 + k));
        end
      end
      CODE_ALT_ONE: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_SYNC_ZERO + k] = at(PORT_E, 3'(k));
        end
      end
      default: ;
    endcase
    // Two-wire one, host and dual pins
    case (route.two_wire_one_sel)
      CODE_DEFAULT: begin
        place[SIG_TWO_WIRE_ONE] = at(PORT_F, 3'h2);
        place[SIG_TWO_WIRE_ONE + 1] = at(PORT_F, 3'h3);
        place[SIG_TWO_WIRE_ONE + 2] = at(PORT_B, 3'h2);
        place[SIG_TWO_WIRE_ONE + 3] = at(PORT_B, 3'h3);
      end
      CODE_ALT_ONE: begin
        place[SIG_TWO_WIRE_ONE] = at(PORT_F, 3'h2);
        place[SIG_TWO_WIRE_ONE + 1] = at(PORT_F, 3'h3);
        place[SIG_TWO_WIRE_ONE + 2] = at(PORT_B, 3'h6);
        place[SIG_TWO_WIRE_ONE + 3] = at(PORT_B, 3'h7);
      end
      CODE_ALT_TWO: begin
        place[SIG_TWO_WIRE_ONE] = at(PORT_B, 3'h2);
        place[SIG_TWO_WIRE_ONE + 1] = at(PORT_B, 3'h3);
        place[SIG_TWO_WIRE_ONE + 2] = at(PORT_B, 3'h6);
        place[SIG_TWO_WIRE_ONE + 3] = at(PORT_B, 3'h7);
      end
      default: ;
    endcase
    // Two-wire zero, host and dual pins
    case (route.two_wire_zero_sel)
      CODE_DEFAULT: begin
        place[SIG_TWO_WIRE_ZERO] = at(PORT_A, 3'h2);
        place[SIG_TWO_WIRE_ZERO + 1] = at(PORT_A, 3'h3);
        place[SIG_TWO_WIRE_ZERO + 2] = at(PORT_C, 3'h2);
        place[SIG_TWO_WIRE_ZERO + 3] = at(PORT_C, 3'h3);
      end
      CODE_ALT_ONE: begin
        place[SIG_TWO_WIRE_ZERO] = at(PORT_A, 3'h2);
        place[SIG_TWO_WIRE_ZERO + 1] = at(PORT_A, 3'h3);
        place[SIG_TWO_WIRE_ZERO + 2] = at(PORT_C, 3'h6);
        place[SIG_TWO_WIRE_ZERO + 3] = at(PORT_C, 3'h7);
      end
      CODE_ALT_TWO: begin
        place[SIG_TWO_WIRE_ZERO] = at(PORT_C, 3'h2);
        place[SIG_TWO_WIRE_ZERO + 1] = at(PORT_C, 3'h3);
        place[SIG_TWO_WIRE_ZERO + 2] = at(PORT_C, 3'h6);
        place[SIG_TWO_WIRE_ZERO + 3] = at(PORT_C, 3'h7);
      end
      default: ;
    endcase
    // Timer A one, outputs 3-5 only on port B
    case (route.timer_a_one_sel)
      3'h0: begin
        for (int k = 0; k < 6; k++) begin
          place[SIG_TIMER_A_ONE + k] = at(PORT_B, 3'(k));
        end
      end
      3'h1: begin
        for (int k = 0; k < 3; k++) begin
          place[SIG_TIMER_A_ONE + k] = at(PORT_C, 3'(4 + k));
        end
      end
      3'h2: begin
        for (int k = 0; k < 3; k++) begin
          place[SIG_TIMER_A_ONE + k] = at(PORT_E, 3'(4 + k));
        end
      end
      default: ;
    endcase
    // Timer A zero, code is the port number
    case (route.timer_a_zero_sel)
      3'h0: begin
        for (int k = 0; k < 6; k++) begin
          place[SIG_TIMER_A_ZERO + k] = at(PORT_A, 3'(k));
        end
      end
      3'h1: begin
        for (int k = 0; k < 6; k++) begin
          place[SIG_TIMER_A_ZERO + k] = at(PORT_B, 3'(k));
        end
      end
      3'h2: begin
        for (int k = 0; k < 6; k++) begin
          place[SIG_TIMER_A_ZERO + k] = at(PORT_C, 3'(k));
        end
      end
      3'h3: begin
        for (int k = 0; k < 6; k++) begin
          place[SIG_TIMER_A_ZERO + k] = at(PORT_D, 3'(k));
        end
      end
      3'h4: begin
        for (int k = 0; k < 6; k++) begin
          place[SIG_TIMER_A_ZERO + k] = at(PORT_E, 3'(k));
        end
      end
      3'h5: begin
        for (int k = 0; k < 6; k++) begin
          place[SIG_TIMER_A_ZERO + k] = at(PORT_F, 3'(k));
        end
      end
      default: ;
    endcase
    // Timer B outputs always have a pin
    // Timer B zero
    case (route.timer_b_sel[0])
      1'b0: place[SIG_TIMER_B] = at(PORT_A, 3'h2);
      1'b1: place[SIG_TIMER_B] = at(PORT_F, 3'h4);
      default: ;
    endcase
    case (route.timer_b_sel[1])
      1'b0: place[SIG_TIMER_B + 1] = at(PORT_A, 3'h3);
      1'b1: place[SIG_TIMER_B + 1] = at(PORT_F, 3'h5);
      default: ;
    endcase
    case (route.timer_b_sel[2])
      1'b0: place[SIG_TIMER_B + 2] = at(PORT_C, 3'h0);
      1'b1: place[SIG_TIMER_B + 2] = at(PORT_B, 3'h4);
      default: ;
    endcase
    case (route.timer_b_sel[3])
      1'b0: place[SIG_TIMER_B + 3] = at(PORT_B, 3'h5);
      1'b1: place[SIG_TIMER_B + 3] = at(PORT_C, 3'h1);
      default: ;
    endcase
    case (route.timer_d_zero_sel)
      3'h0: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_TIMER_D + k] = at(PORT_A, 3'(4 + k));
        end
      end
      3'h1: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_TIMER_D + k] = at(PORT_B, 3'(4 + k));
        end
      end
      3'h2: begin
        for (int k = 0; k < 4; k++) begin
          place[SIG_TIMER_D + k] = at(PORT_F, 3'(k));
        end
      end
      default: ;
    endcase
    for (int k = 0; k < 3; k++) begin
      place[SIG_COMPARATOR + k] = route.comparator_sel[k] ?
                                  at(PORT_C, 3'h6) : at(PORT_A, 3'h7);
    end
    for (int k = 0; k < 2; k++) begin
      place[SIG_ZERO_CROSS + k] = route.zero_cross_sel[k] ?
                                  at(PORT_C, 3'h7) : at(PORT_A, 3'h7);
    end
  end

  // Unplaced signals drive nothing
  // Lowest numbered driving signal wins a shared pin
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      nxt_pin_oe[p] = 1'b0;
      nxt_pin_out[p] = 1'b0;
      for (int s = NUM_SIGS - 1; s >= 0; s--) begin
        if (place[s].vld && place[s].pin == 6'(p) && sig_oe[s]) begin
          nxt_pin_oe[p] = 1'b1;
          nxt_pin_out[p] = sig_out[s];
        end
      end
    end
  end

  always_comb begin
    for (int s = 0; s < NUM_SIGS; s++) begin
      nxt_sig_in[s] = place[s].vld ? pin_in[place[s].pin] : SIG_IDLE[s];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sig_in_ff <= SIG_IDLE;
    end else begin
      sig_in_ff <= nxt_sig_in;
    end
  end

  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign sig_in = sig_in_ff;

endmodule : prps_route_top

/* bench/prps_route_asserts.sv */
// Checker for the pin route selector, watching the top module ports.
// Assumes the bind below; mirrors the serial route field from writes.
`timescale 1ns/1ps
module prps_route_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [prps_pkg::NUM_SIGS-1:0] sig_out,
  input wire logic [prps_pkg::NUM_SIGS-1:0] sig_oe,
  input wire logic [prps_pkg::NUM_SIGS-1:0] sig_in,
  input wire logic [prps_pkg::NUM_PINS-1:0] pin_in,
  input wire logic [prps_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [prps_pkg::NUM_PINS-1:0] pin_oe
);
  import prps_pkg::*;
  logic [1:0] ser_ff;
  logic wr_done;
  assign wr_done = avs_write && !avs_waitrequest;
  // Serial route field as last written
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ser_ff <= 2'h0;
    end else if (wr_done && avs_address == 6'h0C && avs_byteenable[0]) begin
      ser_ff <= avs_writedata[1:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  one_wait_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  answer_bound_a: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##[1:2] !avs_waitrequest)
    else $error("request not answered in time");
  idle_no_wait_a: assert property (
    !avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest without request");
  upper_zero_a: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  serial_readback_a: assert property (
    avs_read && !avs_waitrequest && avs_address == 6'h0C
    |-> avs_readdata[7:0] == {6'h00, ser_ff})
    else $error("serial route reads back wrong");
  reset_idle_a: assert property (
    $fell(sys_rst) |-> pin_oe == '0 && sig_in == SIG_IDLE)
    else $error("pins not idle after reset");
  rx_default_a: assert property (
    !sys_rst && ser_ff == 2'h0 |=> sig_in[1] == $past(pin_in[33]))
    else $error("serial receive not fed from default pin");
  tx_alt_a: assert property (
    !sys_rst && ser_ff == 2'h1 && sig_oe[0]
    |=> pin_oe[36] && pin_out[36] == $past(sig_out[0]))
    else $error("serial transmit not on alternate pin");
  rx_none_a: assert property (
    !sys_rst && ser_ff == 2'h3 |=> sig_in[1] == SIG_IDLE[1])
    else $error("disconnected receive not idle");
  write_seen_c: cover property (wr_done);
  serial_alt_c: cover property (ser_ff == 2'h1 && sig_oe[0]);
  serial_none_c: cover property (ser_ff == 2'h3);
endmodule : prps_route_asserts

bind prps_route_top prps_route_asserts u_chk (.clk_sys, .sys_rst,
  .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .sig_out, .sig_oe, .sig_in, .pin_in,
  .pin_out, .pin_oe);

/* bench/prps_pin_board.sv */
// Pin board model: a pin reads its own driver, else the bench's
// external source, else a weak pull-up. Combinational, no clock.
`timescale 1ns/1ps
module prps_pin_board (
  input wire logic [prps_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic [prps_pkg::NUM_PINS-1:0] pin_out,
  input wire logic ext_oe,
  input wire logic ext_lvl,
  output logic [prps_pkg::NUM_PINS-1:0] pin_in
);
  import prps_pkg::*;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_oe ? ext_lvl : 1'b1);
    end
  end
endmodule : prps_pin_board

/* bench/test_peripheral_pin_route_select.sv */
// Testbench for the pin route selector: register access, refusals,
// reset values and route tables of every peripheral group.
// Assumes the pin board model closes the loop on the pin side.
`timescale 1ns/1ps
module test_peripheral_pin_route_select;
  import prps_pkg::*;
  logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic ext_oe, ext_lvl;
  logic [5:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [NUM_SIGS-1:0] sig_out, sig_oe, sig_in;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe;
  int fails, check_count;
  localparam logic [7:0] MASKS [8] = '{MASK_SERIAL_ROUTE_B,
    MASK_SYNC_SERIAL_ROUTE, MASK_TWO_WIRE_ROUTE, MASK_TIMER_A_ROUTE,
    MASK_TIMER_B_ROUTE, MASK_TIMER_D_ROUTE, MASK_COMPARATOR_ROUTE,
    MASK_ZERO_CROSS_ROUTE};
  // Byte address, write data, signal, expected pin (FF: none)
  localparam logic [31:0] TBL [50] = '{
    32'h0C000020, 32'h0C010024, 32'h0C0300FF, 32'h0C0201FF, 32'h0C010125,
    32'h10000410, 32'h10040414, 32'h1008060E, 32'h100C04FF, 32'h10000804,
    32'h10010B23, 32'h100308FF, 32'h14000C2A, 32'h14000E0A, 32'h14040F0F,
    32'h14080C0A, 32'h140C0CFF, 32'h14001002, 32'h14001212, 32'h14011317,
    32'h14021113, 32'h140310FF, 32'h1800190D, 32'h18081414, 32'h18101626,
    32'h180817FF, 32'h181814FF, 32'h18061AFF, 32'h1C00230D, 32'h1C082311,
    32'h1C002210, 32'h1C04220C, 32'h1C002103, 32'h1C02212D, 32'h1C002002,
    32'h1C01202C, 32'h20002404, 32'h2001250D, 32'h2002272B, 32'h200324FF,
    32'h24002807, 32'h24012816, 32'h24022916, 32'h24042A16, 32'h24032A07,
    32'h28002C07, 32'h28022C17, 32'h28012B17, 32'h28022B07, 32'h100209FF};

  prps_route_top uut (.clk_sys, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .sig_out, .sig_oe, .sig_in, .pin_in, .pin_out,
    .pin_oe);
  prps_pin_board board (.pin_oe, .pin_out, .ext_oe, .ext_lvl, .pin_in);

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_pins(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_pins

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a,
      input logic [7:0] wd, input logic [3:0] be);
    int n;
    logic w;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest and read data taken at the same rising edge
    do begin
      @(posedge clk_sys);
      n++;
      w = avs_waitrequest;
    end while (w !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check_reg({31'h0, w}, 32'h0);
  endtask : bus

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    check_reg(rd, exp);
  endtask : rd_chk

  // One signal alone: drive it out, then read its pin back into it
  task automatic route_case(input logic [31:0] e);
    logic [5:0] s, p;
    logic none;
    s = e[13:8];
    p = e[5:0];
    none = (e[7:0] == 8'hFF);
    bus(1'b1, e[29:24], e[23:16], 4'h1);
    sig_oe <= 45'h1 << s;
    sig_out <= 45'h1 << s;
    ext_oe <= 1'b1;
    ext_lvl <= 1'b0;
    @(posedge clk_sys);
    #1;
    check_pins(pin_oe, none ? 48'h0 : 48'h1 << p);
    if (!none) check_pins({47'h0, pin_out[p]}, 48'h1);
    @(posedge clk_sys);
    sig_oe <= '0;
    repeat (2) @(posedge clk_sys);
    #1;
    check_pins({47'h0, sig_in[s]}, {47'h0, none ? SIG_IDLE[s] : 1'b0});
    @(posedge clk_sys);
    ext_lvl <= 1'b1;
    @(posedge clk_sys);
    #1;
    check_pins({47'h0, sig_in[s]}, {47'h0, none ? SIG_IDLE[s] : 1'b1});
    @(posedge clk_sys);
  endtask : route_case

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run;
  end

  initial begin
    fails = 0;
    check_count = 0;
    sys_rst = 1'b1;
    {avs_read, avs_write, ext_oe, ext_lvl} = 4'h0;
    avs_address = '0;
    avs_byteenable = '0;
    avs_writedata = '0;
    sig_out = '0;
    sig_oe = '0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_chk(6'(12 + 4 * i), 32'h0);
      bus(1'b1, 6'(12 + 4 * i), 8'hFF, 4'h1);
      rd_chk(6'(12 + 4 * i), {24'h0, MASKS[i]});
      bus(1'b1, 6'(12 + 4 * i), 8'h00, 4'h1);
    end
    $display("test reset_and_readback done");
    bus(1'b1, 6'h0C, 8'h02, 4'h1);
    rd_chk(6'h2C, 32'h1);
    bus(1'b1, 6'h2C, 8'hFF, 4'h1);
    rd_chk(6'h2C, 32'h1);
    bus(1'b1, 6'h0C, 8'h01, 4'h0);
    rd_chk(6'h0C, 32'h2);
    bus(1'b1, 6'h30, 8'hFF, 4'h1);
    rd_chk(6'h30, 32'h0);
    rd_chk(6'h0D, 32'h0);
    bus(1'b1, 6'h28, 8'h03, 4'h1);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk(6'h28, 32'h0);
    rd_chk(6'h0C, 32'h0);
    $display("test refusals_and_reset done");
    foreach (TBL[i]) route_case(TBL[i]);
    for (int k = 0; k < 6; k++) route_case({8'h18, 8'(k), 8'(26 + k),
      8'(9 * k)});
    $display("test route_tables done");
    complete_run;
  end
endmodule : test_peripheral_pin_route_select
